// ### hw/host_port_consts.vh
// constants of the multi-style host access port
// Functional notes
// - strap 5 serial,4 cs,3 rw,2 mux,1 boot
// - strap sampled once after reset release
// - cs style: access starts at cs fall
// - ack rises after cs fall, falls when done
// - cs style: write data at cs rise, release
// - rw style: separate read/write strobes with cs
// - ready low after read strobe, high data ready
// - ready low after write strobe, capture at rise
// - mux style latches address at ale fall
// - serial: address, rw, data, lsb first
// - serial input sampled on sclk rising edge
// - serial output edge chosen by edge select
// - edge select is serial address bit 1
// - serial clock may stop between accesses
`ifndef HOST_PORT_CONSTS_VH
`define HOST_PORT_CONSTS_VH
`define STYLE_BOOT     3'h1
`define STYLE_MUX      3'h2
`define STYLE_RW       3'h3
`define STYLE_CS       3'h4
`define STYLE_SERIAL   3'h5
`define ADDR_W         7
`define DATA_W         8
`define SER_RW_BIT     7
`define SER_DATA_FIRST 8
`define SER_LAST_BIT   15
`define EDGE_SEL_BIT   1
// register access latency in ns (internal access time)
`define ACCESS_NS      20
`define CLK_NS         4
`define ACCESS_CYC     ((`ACCESS_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ### hw/host_port.v
// multi-style host access port: parallel, multiplexed and serial register access
`include "host_port_consts.vh"
module host_port (
	// clock and reset
	input  wire       clk,
	input  wire       rstn,
	// strap
	input  wire [2:0] bus_style_strap,
	// parallel host pins
	input  wire       chip_select_n,
	input  wire       write_strobe_n,
	input  wire       read_strobe_n,
	input  wire       addr_latch_en,
	input  wire [6:0] addr_in,
	input  wire [7:0] data_in,
	output reg  [7:0] data_out_ff,
	output reg        data_oe_ff,
	output reg        transfer_acknowledge_ff,
	output reg        ack_oe_ff,
	// serial host pins
	input  wire       serial_clk,
	input  wire       serial_in,
	output reg        serial_out_ff,
	output reg        serial_oe_ff,
	// internal register file side
	output reg        reg_wr_ff,
	output reg  [6:0] reg_addr_ff,
	output reg  [7:0] reg_wdata_ff,
	input  wire [7:0] reg_rdata,
	output reg  [2:0] active_style_ff
);
	localparam ST_IDLE = 2'h0;
	localparam ST_WAIT = 2'h1;
	localparam ST_DONE = 2'h2;
	localparam integer ACC_INT = `ACCESS_CYC;
	localparam [3:0] ACC_CYC = ACC_INT[3:0];

	// two-flop synchronisers for every pin input; the second stage alone feeds logic
	reg [4:0]  pin_s1_ff;
	reg [4:0]  pin_s2_ff;
	reg [2:0]  strap_s1_ff;
	reg [2:0]  strap_s2_ff;
	reg        strap_taken_ff;
	reg [1:0]  strap_fill_ff;
	reg [4:0]  pin_d_ff;
	wire       cs_n    = pin_s2_ff[0];
	wire       wr_n    = pin_s2_ff[1];
	wire       rd_n    = pin_s2_ff[2];
	wire       ale     = pin_s2_ff[3];
	wire       sclk    = pin_s2_ff[4];
	// bus fields pass through a two-flop chain of the same depth as the strobes, so both line up
	reg [6:0]  addr_s1_ff;
	reg [6:0]  addr_s2_ff;
	reg [7:0]  data_s1_ff;
	reg [7:0]  data_s2_ff;
	reg        sdi_s1_ff;
	reg        sdi_s2_ff;

	function edge_fall;
		input now;
		input was;
		edge_fall = was & ~now;
	endfunction

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pin_s1_ff   <= 5'h07; // idle levels: strobes high, latch and serial clock low
			pin_s2_ff   <= 5'h07;
			pin_d_ff    <= 5'h07; // matches idle pins, so no false edge follows reset
			strap_s1_ff <= 3'h0;
			strap_s2_ff <= 3'h0;
			addr_s1_ff  <= 7'h00;
			addr_s2_ff  <= 7'h00;
			data_s1_ff  <= 8'h00;
			data_s2_ff  <= 8'h00;
			sdi_s1_ff   <= 1'b0;
			sdi_s2_ff   <= 1'b0;
		end else begin
			pin_s1_ff   <= {serial_clk, addr_latch_en, read_strobe_n, write_strobe_n, chip_select_n};
			pin_s2_ff   <= pin_s1_ff;
			pin_d_ff    <= pin_s2_ff;
			strap_s1_ff <= bus_style_strap;
			strap_s2_ff <= strap_s1_ff;
			addr_s1_ff  <= addr_in;
			addr_s2_ff  <= addr_s1_ff;
			data_s1_ff  <= data_in;
			data_s2_ff  <= data_s1_ff;
			sdi_s1_ff   <= serial_in;
			sdi_s2_ff   <= sdi_s1_ff;
		end
	end

	// strap taken once the synchroniser holds real pin values, not its reset zeros; later changes are ignored
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			strap_fill_ff   <= 2'h0;
			strap_taken_ff  <= 1'b0;
			active_style_ff <= 3'h0;
		end else begin
			strap_fill_ff <= {strap_fill_ff[0], 1'b1};
			if (strap_fill_ff[1] && !strap_taken_ff) begin
				strap_taken_ff  <= 1'b1;
				active_style_ff <= strap_s2_ff;
			end
		end
	end

	// style decode; boot reading is handled by a separate sequencer, so the port stays quiet
	wire sty_cs  = strap_taken_ff && active_style_ff == `STYLE_CS;
	wire sty_rw  = strap_taken_ff && active_style_ff == `STYLE_RW;
	wire sty_mux = strap_taken_ff && active_style_ff == `STYLE_MUX;
	wire sty_ser = strap_taken_ff && active_style_ff == `STYLE_SERIAL;
	wire sty_par = sty_cs | sty_rw | sty_mux;

	wire cs_fall   = edge_fall(cs_n, pin_d_ff[0]);
	wire cs_rise   = edge_fall(pin_d_ff[0], cs_n);
	wire wr_fall   = edge_fall(wr_n, pin_d_ff[1]);
	wire wr_rise   = edge_fall(pin_d_ff[1], wr_n);
	wire rd_fall   = edge_fall(rd_n, pin_d_ff[2]);
	wire rd_rise   = edge_fall(pin_d_ff[2], rd_n);
	wire ale_fall  = edge_fall(ale, pin_d_ff[3]);
	wire sclk_rise = edge_fall(pin_d_ff[4], sclk);
	wire sclk_fall = edge_fall(sclk, pin_d_ff[4]);

	reg [1:0]  state_ff;
	reg [3:0]  wait_cnt_ff;
	reg        is_write_ff;
	reg [6:0]  mux_addr_ff;
	reg [6:0]  ser_addr_ff;
	reg        ser_wr_ff;
	reg [7:0]  ser_wdata_ff;

	// parallel access sequencer
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_ff                <= ST_IDLE;
			wait_cnt_ff             <= 4'h0;
			is_write_ff             <= 1'b0;
			mux_addr_ff             <= 7'h00;
			data_out_ff             <= 8'h00;
			data_oe_ff              <= 1'b0;
			transfer_acknowledge_ff <= 1'b0;
			ack_oe_ff               <= 1'b0;
			reg_wr_ff               <= 1'b0;
			reg_addr_ff             <= 7'h00;
			reg_wdata_ff            <= 8'h00;
		end else begin
			reg_wr_ff <= 1'b0;
			if (sty_mux && ale_fall)
				mux_addr_ff <= data_s2_ff[6:0];
			if (!sty_par) begin
				// disabled or other style: ignore strobes, stay off the bus
				state_ff   <= ST_IDLE;
				data_oe_ff <= 1'b0;
				ack_oe_ff  <= 1'b0;
				if (sty_ser) begin
					// serial frames reach the register file through the same address and strobe
					reg_addr_ff <= ser_addr_ff;
					if (ser_wr_ff) begin
						reg_wr_ff    <= 1'b1;
						reg_wdata_ff <= ser_wdata_ff;
					end
				end
			end else if (cs_rise) begin
				// chip select gone: release data and ready
				if (sty_cs && is_write_ff) begin
					reg_wr_ff    <= 1'b1;
					reg_wdata_ff <= data_s2_ff;
				end
				state_ff                <= ST_IDLE;
				data_oe_ff              <= 1'b0;
				ack_oe_ff               <= 1'b0;
				transfer_acknowledge_ff <= 1'b0;
			end else if (sty_cs) begin
				case (state_ff)
					ST_IDLE: if (cs_fall) begin
						is_write_ff             <= ~wr_n;
						reg_addr_ff             <= addr_s2_ff;
						ack_oe_ff               <= 1'b1;
						transfer_acknowledge_ff <= 1'b1;
						wait_cnt_ff             <= ACC_CYC;
						state_ff                <= ST_WAIT;
					end
					ST_WAIT: if (wait_cnt_ff == 4'h0) begin
						if (!is_write_ff) begin
							data_out_ff <= reg_rdata;
							data_oe_ff  <= 1'b1;
						end
						transfer_acknowledge_ff <= 1'b0;
						state_ff                <= ST_DONE;
					end else begin
						wait_cnt_ff <= wait_cnt_ff - 4'h1;
					end
					default: state_ff <= ST_DONE;
				endcase
			end else begin
				// read/write-strobed and multiplexed styles share this path
				if (cs_fall) begin
					ack_oe_ff               <= 1'b1;
					transfer_acknowledge_ff <= 1'b1;
				end
				case (state_ff)
					ST_IDLE: if (!cs_n && (rd_fall || wr_fall)) begin
						is_write_ff             <= wr_fall;
						reg_addr_ff             <= sty_mux ? mux_addr_ff : addr_s2_ff;
						transfer_acknowledge_ff <= 1'b0;
						wait_cnt_ff             <= ACC_CYC;
						state_ff                <= ST_WAIT;
					end
					ST_WAIT: if (wait_cnt_ff == 4'h0) begin
						if (!is_write_ff) begin
							data_out_ff <= reg_rdata;
							data_oe_ff  <= 1'b1;
						end
						transfer_acknowledge_ff <= 1'b1;
						state_ff                <= ST_DONE;
					end else begin
						wait_cnt_ff <= wait_cnt_ff - 4'h1;
					end
					default: if (is_write_ff && wr_rise) begin
						reg_wr_ff    <= 1'b1;
						reg_wdata_ff <= data_s2_ff;
						state_ff     <= ST_IDLE;
					end else if (!is_write_ff && rd_rise) begin
						data_oe_ff <= 1'b0;
						state_ff   <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// serial engine; works only on observed sclk edges, so a stopped clock is harmless
	reg [4:0]  bit_cnt_ff;
	reg        ser_read_ff;
	reg [7:0]  ser_shift_ff;
	wire       out_edge = ser_addr_ff[`EDGE_SEL_BIT] ? sclk_fall : sclk_rise;

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bit_cnt_ff    <= 5'h00;
			ser_addr_ff   <= 7'h00;
			ser_read_ff   <= 1'b0;
			ser_shift_ff  <= 8'h00;
			ser_wr_ff     <= 1'b0;
			ser_wdata_ff  <= 8'h00;
			serial_out_ff <= 1'b0;
			serial_oe_ff  <= 1'b0;
		end else begin
			ser_wr_ff <= 1'b0;
			if (!sty_ser || cs_n) begin
				// frame ends with chip select, not with the serial clock
				bit_cnt_ff   <= 5'h00;
				serial_oe_ff <= 1'b0;
				ser_read_ff  <= 1'b0;
			end else begin
				if (sclk_rise && bit_cnt_ff <= 5'd`SER_LAST_BIT) begin
					bit_cnt_ff <= bit_cnt_ff + 5'h01;
					if (bit_cnt_ff < 5'd`SER_RW_BIT)
						ser_addr_ff[bit_cnt_ff[2:0]] <= sdi_s2_ff;
					else if (bit_cnt_ff == 5'd`SER_RW_BIT) begin
						ser_read_ff  <= sdi_s2_ff;
						ser_shift_ff <= reg_rdata;
					end else begin
						ser_wdata_ff[bit_cnt_ff[2:0]] <= sdi_s2_ff;
						if (bit_cnt_ff == 5'd`SER_LAST_BIT && !ser_read_ff)
							ser_wr_ff <= 1'b1;
					end
				end
				if (ser_read_ff && out_edge && bit_cnt_ff >= 5'd`SER_DATA_FIRST) begin
					serial_out_ff <= ser_shift_ff[0];
					ser_shift_ff  <= {1'b0, ser_shift_ff[7:1]};
					serial_oe_ff  <= 1'b1;
				end
			end
		end
	end

endmodule

// ### tb/host_port_chk.sv
// concurrent checks on the host port pins
module host_port_chk (
	// clock and reset
	input wire logic       clk,
	input wire logic       rstn,
	// host strobes
	input wire logic       chip_select_n,
	input wire logic       read_strobe_n,
	// design outputs
	input wire logic       data_oe_ff,
	input wire logic       transfer_acknowledge_ff,
	input wire logic       ack_oe_ff,
	input wire logic       serial_oe_ff,
	input wire logic       reg_wr_ff,
	input wire logic [2:0] active_style_ff
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// style flags, kept short so each property stays on two lines
	wire cs_st = active_style_ff == 3'h4;
	wire rw_st = active_style_ff == 3'h3;
	chk_off_quiet: assert property (!(active_style_ff inside {3'h2, 3'h3, 3'h4, 3'h5}) |->
		!data_oe_ff && !ack_oe_ff && !serial_oe_ff) else $error("pins driven while port is off");
	chk_serial_only: assert property (serial_oe_ff |-> active_style_ff == 3'h5)
		else $error("serial output driven outside serial style");
	chk_par_only: assert property (data_oe_ff |-> active_style_ff inside {3'h2, 3'h3, 3'h4})
		else $error("parallel data driven outside parallel styles");
	chk_wr_style: assert property (reg_wr_ff |-> active_style_ff inside {3'h2, 3'h3, 3'h4, 3'h5})
		else $error("register write while port is off");
	// the strap lands three edges after release, so look back four
	chk_style_hold: assert property ($past(rstn, 4) |-> $stable(active_style_ff))
		else $error("bus style changed after power up");
	chk_cs_ack_up: assert property (cs_st && $fell(chip_select_n) |-> ##[1:4] transfer_acknowledge_ff && ack_oe_ff)
		else $error("acknowledge did not rise after select");
	chk_cs_ack_down: assert property (cs_st && $rose(transfer_acknowledge_ff) |-> ##[2:10] !transfer_acknowledge_ff)
		else $error("acknowledge did not fall at completion");
	chk_cs_release: assert property (cs_st && $rose(chip_select_n) |-> ##[1:5] !data_oe_ff && !ack_oe_ff)
		else $error("bus not released after select rise");
	chk_rw_ready_low: assert property (rw_st && !chip_select_n && $fell(read_strobe_n) |->
		##[1:4] !transfer_acknowledge_ff && ack_oe_ff) else $error("ready not pulled low after read strobe");
	chk_wr_pulse: assert property (reg_wr_ff |=> !reg_wr_ff)
		else $error("register write longer than one cycle");
	cover property (cs_st && $rose(chip_select_n));
	cover property (rw_st && $rose(transfer_acknowledge_ff));
	cover property ($rose(serial_oe_ff));
	cover property (active_style_ff == 3'h2 && reg_wr_ff);
endmodule
bind host_port host_port_chk chk (.clk, .rstn, .chip_select_n, .read_strobe_n, .data_oe_ff,
	.transfer_acknowledge_ff, .ack_oe_ff, .serial_oe_ff, .reg_wr_ff, .active_style_ff);

// ### tb/host_model.sv
// processor model driving the parallel and serial host pins
module host_model (
	// clock and answers
	input wire logic        clk,
	input wire logic        transfer_acknowledge_ff,
	input wire logic [7:0]  data_out_ff,
	input wire logic        data_oe_ff,
	input wire logic        serial_out_ff,
	input wire logic        serial_oe_ff,
	// host pins
	output logic            chip_select_n,
	output logic            write_strobe_n,
	output logic            read_strobe_n,
	output logic            addr_latch_en,
	output logic [6:0]      addr_in,
	output logic [7:0]      data_in,
	output logic            serial_clk,
	output logic            serial_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle pins; the serial clock stands low between frames
	initial begin
		{chip_select_n, write_strobe_n, read_strobe_n, addr_latch_en} = 4'h e;
		{addr_in, data_in, serial_clk, serial_in} = 17'h0;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// bounded wait, a hung port shows up as a wrong answer
	task automatic wait_ack(input logic lvl);
		for (int i = 0; i < 30 && transfer_acknowledge_ff !== lvl; i++) cyc(1);
	endtask
	task automatic cs_access(input logic wr, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
		addr_in = a;
		data_in = d;
		write_strobe_n = !wr;
		cyc(1);
		chip_select_n = 1'b0;
		wait_ack(1'b1);
		wait_ack(1'b0);
		q = data_oe_ff ? data_out_ff : ~data_out_ff;
		chip_select_n = 1'b1;
		cyc(4);
		write_strobe_n = 1'b1;
		data_in = ~d;
		cyc(40);
	endtask
	// strobed access; in multiplexed style the address rides the data bus and addr_in carries a decoy
	task automatic rw_access(input logic mux, input logic wr, input logic [6:0] a, input logic [7:0] d,
		output logic [7:0] q);
		addr_in = mux ? ~a : a;
		data_in = mux ? {1'b0, a} : d;
		if (mux) begin
			addr_latch_en = 1'b1;
			cyc(1);
			addr_latch_en = 1'b0;
			cyc(3);
			data_in = d;
		end
		chip_select_n = 1'b0;
		wait_ack(1'b1);
		if (wr) write_strobe_n = 1'b0;
		else read_strobe_n = 1'b0;
		wait_ack(1'b0);
		wait_ack(1'b1);
		q = data_oe_ff ? data_out_ff : ~data_out_ff;
		write_strobe_n = 1'b1;
		read_strobe_n = 1'b1;
		cyc(4);
		chip_select_n = 1'b1;
		data_in = ~d;
		cyc(mux && wr ? 400 : 40);
	endtask
	// host takes each output bit half a serial clock after the edge that launches it
	task automatic ser_access(input logic wr, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
		logic [15:0] f;
		f = {d, ~wr, a};
		chip_select_n = 1'b0;
		cyc(4);
		for (int i = 0; i < 16; i++) begin
			serial_in = f[i];
			cyc(6);
			if (a[1] && i > 7) q[i-8] = serial_oe_ff ? serial_out_ff : ~serial_out_ff;
			serial_clk = 1'b1;
			cyc(6);
			if (!a[1] && i > 7) q[i-8] = serial_oe_ff ? serial_out_ff : ~serial_out_ff;
			serial_clk = 1'b0;
		end
		cyc(4);
		chip_select_n = 1'b1;
		serial_in = ~serial_in;
		cyc(4);
	endtask
endmodule

// ### tb/test_multi_mode_host_interface.sv
// self-checking bench of the multi-style host port
module test_multi_mode_host_interface;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk = 0, rstn = 0, chip_select_n, write_strobe_n, read_strobe_n, addr_latch_en;
	logic       serial_clk, serial_in, serial_out_ff, serial_oe_ff, data_oe_ff, transfer_acknowledge_ff;
	logic       ack_oe_ff, reg_wr_ff;
	logic [2:0] bus_style_strap, active_style_ff;
	logic [6:0] addr_in, reg_addr_ff, wr_addr;
	logic [7:0] data_in, data_out_ff, reg_wdata_ff, reg_rdata, wr_data, n_wr = 0;
	int         n_mismatch = 0, check_count = 0;
	host_model host (.clk, .transfer_acknowledge_ff, .data_out_ff, .data_oe_ff, .serial_out_ff, .serial_oe_ff,
		.chip_select_n, .write_strobe_n, .read_strobe_n, .addr_latch_en, .addr_in, .data_in, .serial_clk,
		.serial_in);
	host_port uut (.clk, .rstn, .bus_style_strap, .chip_select_n, .write_strobe_n, .read_strobe_n, .addr_latch_en,
		.addr_in, .data_in, .data_out_ff, .data_oe_ff, .transfer_acknowledge_ff, .ack_oe_ff, .serial_clk,
		.serial_in, .serial_out_ff, .serial_oe_ff, .reg_wr_ff, .reg_addr_ff, .reg_wdata_ff, .reg_rdata,
		.active_style_ff);
	// register file stand-in: read data is a fixed function of the address
	assign reg_rdata = {reg_addr_ff, 1'b0} ^ 8'h3c;
	always @(posedge clk) if (reg_wr_ff) begin
		wr_addr <= reg_addr_ff;
		wr_data <= reg_wdata_ff;
		n_wr <= n_wr + 8'h01;
	end
	initial forever #2 clk = ~clk;
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic restart(input logic [2:0] s);
		rstn = 1'b0;
		bus_style_strap = s;
		host.cyc(2);
		rstn = 1'b1;
		host.cyc(4);
	endtask
	task automatic t_cs;
		logic [7:0] q;
		restart(3'h4);
		check("style", {5'h00, active_style_ff}, 8'h04);
		host.cs_access(1'b1, 7'h15, 8'ha7, q);
		check("cs wr addr", {1'b0, wr_addr}, 8'h15);
		check("cs wr data", wr_data, 8'ha7);
		host.cs_access(1'b0, 7'h22, 8'h00, q);
		check("cs rd data", q, 8'h78);
		bus_style_strap = 3'h5;
		host.cyc(4);
		check("style hold", {5'h00, active_style_ff}, 8'h04);
		check("cs release", {5'h00, data_oe_ff, ack_oe_ff, serial_oe_ff}, 8'h00);
	endtask
	task automatic t_rw;
		logic [7:0] q;
		restart(3'h3);
		check("style", {5'h00, active_style_ff}, 8'h03);
		host.rw_access(1'b0, 1'b1, 7'h33, 8'h5c, q);
		check("rw wr addr", {1'b0, wr_addr}, 8'h33);
		check("rw wr data", wr_data, 8'h5c);
		host.rw_access(1'b0, 1'b0, 7'h7f, 8'h00, q);
		check("rw rd data", q, 8'hc2);
	endtask
	task automatic t_mux;
		logic [7:0] q;
		restart(3'h2);
		check("style", {5'h00, active_style_ff}, 8'h02);
		host.rw_access(1'b1, 1'b1, 7'h2d, 8'h6e, q);
		check("mux wr addr", {1'b0, wr_addr}, 8'h2d);
		check("mux wr data", wr_data, 8'h6e);
		host.rw_access(1'b1, 1'b0, 7'h0a, 8'h00, q);
		check("mux rd data", q, 8'h28);
	endtask
	task automatic t_ser;
		logic [7:0] q;
		restart(3'h5);
		check("style", {5'h00, active_style_ff}, 8'h05);
		host.ser_access(1'b1, 7'h56, 8'h93, q);
		check("ser wr addr", {1'b0, wr_addr}, 8'h56);
		check("ser wr data", wr_data, 8'h93);
		host.ser_access(1'b0, 7'h41, 8'h00, q);
		check("ser rd data", q, 8'hbe);
		host.ser_access(1'b0, 7'h42, 8'h00, q);
		check("ser rd fall", q, 8'hb8);
	endtask
	task automatic t_off;
		logic [7:0] q, n0;
		for (int k = 0; k < 3; k++) begin
			restart(k == 0 ? 3'h0 : 3'h5 + k[2:0]);
			n0 = n_wr;
			host.cs_access(1'b1, 7'h11, 8'h99, q);
			check("off writes", n_wr, n0);
			check("off enables", {5'h00, data_oe_ff, ack_oe_ff, serial_oe_ff}, 8'h00);
		end
	endtask
	task automatic conclude;
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		t_cs;
		t_rw;
		t_mux;
		t_ser;
		t_off;
		conclude;
	end
	// the whole run needs under two thousand cycles
	initial begin
		#200000;
		n_mismatch++;
		conclude;
	end
endmodule
